// *** design/ras_pkg.sv ***
package ras_pkg;

  // ----------------------------------------------------------------
  // bus geometry and responses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_ALARM_SECONDS = 6'h00;
  localparam logic [5:0] OFS_ALARM_HOURS_MINUTES = 6'h04;
  localparam logic [5:0] OFS_ALARM_DAY_WEEKDAY = 6'h08;
  localparam logic [5:0] OFS_ALARM_YEAR_MONTH = 6'h0c;
  localparam logic [5:0] OFS_STAMP_SECONDS = 6'h10;
  localparam logic [5:0] OFS_STAMP_HOURS_MINUTES = 6'h14;
  localparam logic [5:0] OFS_STAMP_DAY_WEEKDAY = 6'h18;
  localparam logic [5:0] OFS_CONTROL = 6'h1c;
  localparam logic [5:0] OFS_STATUS = 6'h20;
  localparam logic [5:0] OFS_INT_ENABLE = 6'h24;
  localparam logic [5:0] OFS_INT_CLEAR = 6'h28;

  // ----------------------------------------------------------------
  // implemented bits of each value word
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_SECONDS = 16'h7f00;
  localparam logic [15:0] MASK_HOURS_MINUTES = 16'h3f7f;
  localparam logic [15:0] MASK_DAY_WEEKDAY = 16'h3f07;
  localparam logic [15:0] MASK_YEAR_MONTH = 16'hff1f;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // control, status and match mask fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_ALARM_ENABLE = 0;
  localparam int unsigned CTL_STAMP_ENABLE = 1;
  localparam int unsigned CTL_STAMP_REQUEST = 2;
  localparam int unsigned CTL_MASK_LSB = 8;
  localparam int unsigned EVT_ALARM = 0;
  localparam int unsigned EVT_STAMP = 1;
  localparam int unsigned EVT_COUNT = 2;
  localparam logic [3:0] MASK_CODE_RESET = 4'h0;
  localparam logic [3:0] AM_HALF_SECOND = 4'h0;
  localparam logic [3:0] AM_SECOND = 4'h1;
  localparam logic [3:0] AM_TEN_SECONDS = 4'h2;
  localparam logic [3:0] AM_MINUTE = 4'h3;
  localparam logic [3:0] AM_TEN_MINUTES = 4'h4;
  localparam logic [3:0] AM_HOUR = 4'h5;
  localparam logic [3:0] AM_DAY = 4'h6;
  localparam logic [3:0] AM_WEEK = 4'h7;
  localparam logic [3:0] AM_MONTH = 4'h8;
  localparam logic [3:0] AM_YEAR = 4'h9;

endpackage

// *** design/ras_alarm_match.sv ***
`timescale 1ns/100ps
module ras_alarm_match (
  input wire logic [15:0] i_alarm_seconds,
  input wire logic [15:0] i_alarm_hours_minutes,
  input wire logic [15:0] i_alarm_day_weekday,
  input wire logic [15:0] i_alarm_year_month,
  input wire logic [15:0] i_time_seconds,
  input wire logic [15:0] i_time_hours_minutes,
  input wire logic [15:0] i_time_day_weekday,
  input wire logic [15:0] i_time_year_month,
  input wire logic [3:0] i_mask,
  input wire logic i_half_tick,
  input wire logic i_second_half,
  output logic o_match
);

  // per-field equality, each code from ten seconds on adds one more field to the compare, except the month code, which trades weekday for day
  logic su, st, mu, mt, hr, wd, dy, mo;
  always_comb begin
    su = i_alarm_seconds[11:8] == i_time_seconds[11:8];
    st = i_alarm_seconds[14:12] == i_time_seconds[14:12];
    mu = i_alarm_hours_minutes[3:0] == i_time_hours_minutes[3:0];
    mt = i_alarm_hours_minutes[6:4] == i_time_hours_minutes[6:4];
    hr = i_alarm_hours_minutes[13:8] == i_time_hours_minutes[13:8];
    wd = i_alarm_day_weekday[2:0] == i_time_day_weekday[2:0];
    dy = i_alarm_day_weekday[13:8] == i_time_day_weekday[13:8];
    mo = i_alarm_year_month[4:0] == i_time_year_month[4:0];
  end

  // reserved mask codes never match, so a bad code cannot chatter
  always_comb begin
    unique case (i_mask)
      ras_pkg::AM_HALF_SECOND: o_match = i_half_tick;
      ras_pkg::AM_SECOND: o_match = i_half_tick && !i_second_half;
      ras_pkg::AM_TEN_SECONDS: o_match = i_half_tick && !i_second_half && su;
      ras_pkg::AM_MINUTE: o_match = i_half_tick && !i_second_half && su && st;
      ras_pkg::AM_TEN_MINUTES: o_match = i_half_tick && !i_second_half && su && st && mu;
      ras_pkg::AM_HOUR: o_match = i_half_tick && !i_second_half && su && st && mu && mt;
      ras_pkg::AM_DAY: o_match = i_half_tick && !i_second_half && su && st && mu && mt && hr;
      ras_pkg::AM_WEEK: o_match = i_half_tick && !i_second_half && su && st && mu && mt && hr && wd;
      ras_pkg::AM_MONTH: o_match = i_half_tick && !i_second_half && su && st && mu && mt && hr && dy;
      ras_pkg::AM_YEAR: o_match = i_half_tick && !i_second_half && su && st && mu && mt && hr && dy && mo;
      default: o_match = 1'b0;
    endcase
  end

endmodule

// *** design/ras_event_irq.sv ***
`timescale 1ns/100ps
module ras_event_irq #(
  parameter int unsigned N = 2
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clear_all,
  input wire logic [N-1:0] i_set,
  input wire logic [N-1:0] i_clear,
  input wire logic [N-1:0] i_enable,
  output logic [N-1:0] o_status,
  output logic o_irq
);

  logic [N-1:0] next_status;

  // sticky bits: an event in an i_clear cycle survives the clear; i_clear_all drops it
  always_comb begin
    next_status = i_clear_all ? '0 : ((o_status & ~i_clear) | i_set);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_status <= '0;
      o_irq <= 1'b0;
    end else begin
      o_status <= next_status;
      o_irq <= |(next_status & i_enable);
    end
  end

endmodule

// *** design/ras_alarm_stamp.sv ***
// What this block does
// - seconds: tens 14:12, units 11:8
// - hours: tens 13:12, units 11:8
// - minutes: tens 6:4, units 3:0, bit7 zero
// - day: tens 13:12, units 11:8
// - weekday in 2:0, bits 7:3 zero
// - year: tens 15:12, units 11:8
// - month: tens bit4, units 3:0
// - stamp words reuse alarm field layout
// - stamps: 16-bit storage, survive soft reset
// - fields reset to zero; unused bits read zero, except in stamp words while stamping is off
// - alarm when masked digits match clock
// - stamp request; flag marks valid capture
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module ras_alarm_stamp (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_soft_rst,
  input wire logic [ras_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ras_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [15:0] i_time_seconds,
  input wire logic [15:0] i_time_hours_minutes,
  input wire logic [15:0] i_time_day_weekday,
  input wire logic [15:0] i_time_year_month,
  input wire logic i_half_tick,
  input wire logic i_second_half,
  input wire logic i_stamp_trigger,
  output logic o_alarm_pulse,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // implemented bits of an alarm word, by index
  function automatic logic [15:0] alarm_mask(input logic [1:0] idx);
    unique case (idx)
      2'h0: alarm_mask = ras_pkg::MASK_SECONDS;
      2'h1: alarm_mask = ras_pkg::MASK_HOURS_MINUTES;
      2'h2: alarm_mask = ras_pkg::MASK_DAY_WEEKDAY;
      default: alarm_mask = ras_pkg::MASK_YEAR_MONTH;
    endcase
  endfunction

  // merge the two low byte lanes into a 16-bit word
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] alarm_word [4];
  logic [15:0] stamp_word [3];
  logic [15:0] next_alarm_word [4];
  logic [15:0] next_stamp_word [3];
  logic alarm_enable, next_alarm_enable;
  logic stamp_enable, next_stamp_enable;
  logic [3:0] match_mask, next_match_mask;
  logic [ras_pkg::EVT_COUNT-1:0] int_enable, next_int_enable;
  logic [ras_pkg::EVT_COUNT-1:0] int_clear;
  logic [ras_pkg::EVT_COUNT-1:0] event_set;
  logic [ras_pkg::EVT_COUNT-1:0] status;
  logic aw_held, next_aw_held;
  logic [ras_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic next_alarm_pulse;
  logic write_go, stamp_request, capture, match, alarm_fire;
  logic [15:0] stamp_view [3];

  // ----------------------------------------------------------------
  // alarm comparator and event flags
  // ----------------------------------------------------------------
  ras_alarm_match u_match (
    .i_alarm_seconds(alarm_word[0]),
    .i_alarm_hours_minutes(alarm_word[1]),
    .i_alarm_day_weekday(alarm_word[2]),
    .i_alarm_year_month(alarm_word[3]),
    .i_time_seconds(i_time_seconds),
    .i_time_hours_minutes(i_time_hours_minutes),
    .i_time_day_weekday(i_time_day_weekday),
    .i_time_year_month(i_time_year_month),
    .i_mask(match_mask),
    .i_half_tick(i_half_tick),
    .i_second_half(i_second_half),
    .o_match(match)
  );

  ras_event_irq #(
    .N(ras_pkg::EVT_COUNT)
  ) u_irq (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear_all(i_soft_rst),
    .i_set(event_set),
    .i_clear(int_clear),
    .i_enable(next_int_enable), // lead the register so irq never lags an enable write
    .o_status(status),
    .o_irq(o_irq)
  );

  // stamp view: full 16 bits while stamping is off, fields only while on
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      stamp_view[i] = stamp_enable ? (stamp_word[i] & alarm_mask(2'(i))) : stamp_word[i];
    end
  end

  // event sources
  always_comb begin
    write_go = aw_held && w_held && !o_bvalid;
    stamp_request = write_go && (aw_addr == ras_pkg::OFS_CONTROL) && w_strb[0]
      && w_data[ras_pkg::CTL_STAMP_REQUEST];
    capture = stamp_enable && (stamp_request || i_stamp_trigger);
    alarm_fire = alarm_enable && match;
    event_set = '0;
    event_set[ras_pkg::EVT_ALARM] = alarm_fire;
    event_set[ras_pkg::EVT_STAMP] = capture;
    int_clear = (write_go && aw_addr == ras_pkg::OFS_INT_CLEAR && w_strb[0])
      ? w_data[ras_pkg::EVT_COUNT-1:0] : '0;
  end

  // ----------------------------------------------------------------
  // value words and control: next state
  // ----------------------------------------------------------------
  // captures override a software write to the same stamp word
  always_comb begin
    next_alarm_word = alarm_word;
    next_stamp_word = stamp_word;
    next_alarm_enable = alarm_enable;
    next_stamp_enable = stamp_enable;
    next_match_mask = match_mask;
    next_int_enable = int_enable;
    if (write_go) begin
      unique case (aw_addr)
        ras_pkg::OFS_ALARM_SECONDS: next_alarm_word[0] = merge(alarm_word[0], w_data, w_strb) & alarm_mask(2'h0);
        ras_pkg::OFS_ALARM_HOURS_MINUTES: next_alarm_word[1] = merge(alarm_word[1], w_data, w_strb) & alarm_mask(2'h1);
        ras_pkg::OFS_ALARM_DAY_WEEKDAY: next_alarm_word[2] = merge(alarm_word[2], w_data, w_strb) & alarm_mask(2'h2);
        ras_pkg::OFS_ALARM_YEAR_MONTH: next_alarm_word[3] = merge(alarm_word[3], w_data, w_strb) & alarm_mask(2'h3);
        ras_pkg::OFS_STAMP_SECONDS: next_stamp_word[0] = merge(stamp_word[0], w_data, w_strb);
        ras_pkg::OFS_STAMP_HOURS_MINUTES: next_stamp_word[1] = merge(stamp_word[1], w_data, w_strb);
        ras_pkg::OFS_STAMP_DAY_WEEKDAY: next_stamp_word[2] = merge(stamp_word[2], w_data, w_strb);
        ras_pkg::OFS_CONTROL: begin
          if (w_strb[0]) begin
            next_alarm_enable = w_data[ras_pkg::CTL_ALARM_ENABLE];
            next_stamp_enable = w_data[ras_pkg::CTL_STAMP_ENABLE];
          end
          if (w_strb[1]) begin
            next_match_mask = w_data[ras_pkg::CTL_MASK_LSB +: 4];
          end
        end
        ras_pkg::OFS_INT_ENABLE: begin
          if (w_strb[0]) begin
            next_int_enable = w_data[ras_pkg::EVT_COUNT-1:0];
          end
        end
        default: ;
      endcase
    end
    if (capture) begin
      next_stamp_word[0] = i_time_seconds & ras_pkg::MASK_SECONDS;
      next_stamp_word[1] = i_time_hours_minutes & ras_pkg::MASK_HOURS_MINUTES;
      next_stamp_word[2] = i_time_day_weekday & ras_pkg::MASK_DAY_WEEKDAY;
    end
    // one-shot alarm: the hit disarms it, beating a same-cycle write
    if (alarm_fire) begin
      next_alarm_enable = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // value words and control: registers
  // ----------------------------------------------------------------
  // soft reset leaves the value words alone; only power-on clears them
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int i = 0; i < 4; i++) begin
        alarm_word[i] <= ras_pkg::WORD_RESET;
      end
      for (int i = 0; i < 3; i++) begin
        stamp_word[i] <= ras_pkg::WORD_RESET;
      end
    end else begin
      alarm_word <= next_alarm_word;
      stamp_word <= next_stamp_word;
    end
  end

  // control clears on either reset
  always_ff @(posedge i_clock) begin
    if (i_rst || i_soft_rst) begin
      alarm_enable <= 1'b0;
      stamp_enable <= 1'b0;
      match_mask <= ras_pkg::MASK_CODE_RESET;
      int_enable <= '0;
      o_alarm_pulse <= 1'b0;
    end else begin
      alarm_enable <= next_alarm_enable;
      stamp_enable <= next_stamp_enable;
      match_mask <= next_match_mask;
      int_enable <= next_int_enable;
      o_alarm_pulse <= next_alarm_pulse;
    end
  end

  always_comb begin
    next_alarm_pulse = alarm_fire;
  end

  // ----------------------------------------------------------------
  // bus slave: next state
  // ----------------------------------------------------------------
  // address and data are caught in either order, then retired together
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = o_bvalid;
    next_bresp = o_bresp;
    if (o_bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    if (i_awvalid && o_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_held = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (write_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = ras_pkg::RESP_OKAY;
      if (aw_addr[1:0] != 2'h0 || aw_addr > ras_pkg::OFS_INT_CLEAR || aw_addr == ras_pkg::OFS_STATUS) begin
        next_bresp = ras_pkg::RESP_SLVERR;
      end
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
  end

  // read answers one cycle after the address is taken
  always_comb begin
    next_rvalid = o_rvalid;
    next_rdata = o_rdata;
    next_rresp = o_rresp;
    if (o_rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      next_rvalid = 1'b1;
      next_rresp = ras_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      unique case (i_araddr)
        ras_pkg::OFS_ALARM_SECONDS: next_rdata[15:0] = alarm_word[0];
        ras_pkg::OFS_ALARM_HOURS_MINUTES: next_rdata[15:0] = alarm_word[1];
        ras_pkg::OFS_ALARM_DAY_WEEKDAY: next_rdata[15:0] = alarm_word[2];
        ras_pkg::OFS_ALARM_YEAR_MONTH: next_rdata[15:0] = alarm_word[3];
        ras_pkg::OFS_STAMP_SECONDS: next_rdata[15:0] = stamp_view[0];
        ras_pkg::OFS_STAMP_HOURS_MINUTES: next_rdata[15:0] = stamp_view[1];
        ras_pkg::OFS_STAMP_DAY_WEEKDAY: next_rdata[15:0] = stamp_view[2];
        ras_pkg::OFS_CONTROL: begin
          next_rdata[ras_pkg::CTL_ALARM_ENABLE] = alarm_enable;
          next_rdata[ras_pkg::CTL_STAMP_ENABLE] = stamp_enable;
          next_rdata[ras_pkg::CTL_MASK_LSB +: 4] = match_mask;
        end
        ras_pkg::OFS_STATUS: next_rdata[ras_pkg::EVT_COUNT-1:0] = status;
        ras_pkg::OFS_INT_ENABLE: next_rdata[ras_pkg::EVT_COUNT-1:0] = int_enable;
        ras_pkg::OFS_INT_CLEAR: ;
        default: next_rresp = ras_pkg::RESP_SLVERR;
      endcase
    end
    next_arready = !next_rvalid;
  end

  // ----------------------------------------------------------------
  // bus slave: registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= ras_pkg::RESP_OKAY;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= ras_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      o_awready <= next_awready;
      o_wready <= next_wready;
      o_bvalid <= next_bvalid;
      o_bresp <= next_bresp;
      o_arready <= next_arready;
      o_rvalid <= next_rvalid;
      o_rdata <= next_rdata;
      o_rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_sec_fields: assert property ((alarm_word[0] & ~ras_pkg::MASK_SECONDS) == 16'h0000)
    else $error("alarm seconds holds unimplemented bits");
  a_hm_fields: assert property ((alarm_word[1] & ~ras_pkg::MASK_HOURS_MINUTES) == 16'h0000)
    else $error("alarm hours/minutes holds unimplemented bits");
  a_date_fields: assert property (((alarm_word[2] & ~ras_pkg::MASK_DAY_WEEKDAY)
    | (alarm_word[3] & ~ras_pkg::MASK_YEAR_MONTH)) == 16'h0000)
    else $error("alarm date word holds unimplemented bits");
  a_upper_zero: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_por_clear: assert property (@(posedge i_clock) disable iff (1'b0)
    i_rst |=> alarm_word[0] == 16'h0000 && stamp_word[0] == 16'h0000)
    else $error("power-on reset left a value word set");
  a_stamp_keep: assert property (i_soft_rst && !write_go && !capture |=> $stable(stamp_word[1]))
    else $error("soft reset disturbed stamp storage");
  a_stamp_capture: assert property (capture |=>
    stamp_word[0] == ($past(i_time_seconds) & ras_pkg::MASK_SECONDS) && status[ras_pkg::EVT_STAMP])
    else $error("stamp capture wrong or flag missing");
  a_alarm_hit: assert property (alarm_fire |=> o_alarm_pulse && !alarm_enable && status[ras_pkg::EVT_ALARM])
    else $error("alarm hit not reported");
  a_no_alarm_off: assert property (!alarm_enable |=> !o_alarm_pulse)
    else $error("alarm pulse while disarmed");
  a_write_resp: assert property (write_go |=> o_bvalid ##0 (o_bvalid && !i_bready) [*1] |=> o_bvalid)
    else $error("write response dropped");
  a_read_resp: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read answer missing");
  a_irq_level: assert property (o_irq == |(status & int_enable))
    else $error("interrupt out of step with status");

  c_alarm: cover property (alarm_fire);
  c_stamp: cover property (capture ##1 o_rvalid);
  c_error: cover property (o_rvalid && o_rresp == ras_pkg::RESP_SLVERR);
  c_irq: cover property (o_irq ##[1:20] !o_irq);

endmodule

// *** tb/ras_alarm_stamp_tb.sv ***
`timescale 1ns/100ps
module ras_alarm_stamp_tb;
  // ----------------------------------------------------------------
  // stimulus signals and design
  // ----------------------------------------------------------------
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_soft_rst = 1'b0;
  logic [5:0] i_awaddr = 6'h00;
  logic [5:0] i_araddr = 6'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hf;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic i_half_tick = 1'b0, i_second_half = 1'b0, i_stamp_trigger = 1'b0;
  logic [15:0] tw [4] = '{default: 16'h0000};
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_alarm_pulse, o_irq;
  logic [1:0] o_bresp, o_rresp, rsp;
  logic [31:0] o_rdata, rdat;
  logic [15:0] msk [4];
  logic [15:0] sv [4];
  logic [15:0] st [3];
  int bad_count = 0;
  int checked = 0;
  int k;
  int c;

  // free-running 125 MHz clock
  always #4 i_clock = ~i_clock;

  ras_alarm_stamp ras_alarm_stamp_i (.i_clock(i_clock), .i_rst(i_rst), .i_soft_rst(i_soft_rst),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .i_time_seconds(tw[0]), .i_time_hours_minutes(tw[1]),
    .i_time_day_weekday(tw[2]), .i_time_year_month(tw[3]), .i_half_tick(i_half_tick),
    .i_second_half(i_second_half), .i_stamp_trigger(i_stamp_trigger),
    .o_alarm_pulse(o_alarm_pulse), .o_irq(o_irq));

  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // a lost handshake counts once and ends the run
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clock);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        rsp = o_bresp;
        i_bready <= 1'b0;
        @(posedge i_clock);
        break;
      end
    end
    if (n == 40) begin
      chk(32'h0, 32'h1);
      print_verdict();
    end
  endtask

  task automatic rc(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    int n;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clock);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        rdat = o_rdata;
        rsp = o_rresp;
        i_rready <= 1'b0;
        @(posedge i_clock);
        break;
      end
    end
    if (n == 40) begin
      chk(32'h0, 32'h1);
      print_verdict();
    end
    chk(rdat, exp);
    chk({30'h0, rsp}, {30'h0, rexp});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    msk = '{ras_pkg::MASK_SECONDS, ras_pkg::MASK_HOURS_MINUTES, ras_pkg::MASK_DAY_WEEKDAY,
      ras_pkg::MASK_YEAR_MONTH};
    void'($urandom(32'h755e));
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    // every value word starts cleared
    for (k = 0; k < 7; k++) rc(6'(k * 4), 32'h0, ras_pkg::RESP_OKAY);
    // alarm words keep only their field bits, no range check
    for (k = 0; k < 4; k++) begin
      sv[k] = 16'($urandom);
      wr(6'(k * 4), {16'hffff, sv[k]});
      rc(6'(k * 4), {16'h0, sv[k] & msk[k]}, ras_pkg::RESP_OKAY);
    end
    // stamp words as plain storage across a trigger and a soft reset
    for (k = 0; k < 3; k++) begin
      st[k] = 16'($urandom);
      wr(6'(16 + k * 4), {16'hffff, st[k]});
    end
    for (k = 0; k < 4; k++) tw[k] <= 16'($urandom) & msk[k];
    i_stamp_trigger <= 1'b1;
    i_soft_rst <= 1'b1;
    @(posedge i_clock);
    i_stamp_trigger <= 1'b0;
    i_soft_rst <= 1'b0;
    @(posedge i_clock);
    rc(ras_pkg::OFS_STATUS, 32'h0, ras_pkg::RESP_OKAY);
    for (k = 0; k < 4; k++) rc(6'(k * 4), {16'h0, sv[k] & msk[k]}, ras_pkg::RESP_OKAY);
    for (k = 0; k < 3; k++) rc(6'(16 + k * 4), {16'h0, st[k]}, ras_pkg::RESP_OKAY);
    // capture of the running time once enabled, by the pin and by the request bit
    wr(ras_pkg::OFS_CONTROL, 32'h2);
    for (c = 0; c < 2; c++) begin
      for (k = 0; k < 4; k++) tw[k] <= 16'($urandom) & msk[k];
      wr(ras_pkg::OFS_INT_CLEAR, 32'h3);
      if (c == 0) begin
        i_stamp_trigger <= 1'b1;
        @(posedge i_clock);
        i_stamp_trigger <= 1'b0;
      end else begin
        wr(ras_pkg::OFS_CONTROL, 32'h6);
      end
      rc(ras_pkg::OFS_STATUS, 32'h2, ras_pkg::RESP_OKAY);
      for (k = 0; k < 3; k++) rc(6'(16 + k * 4), {16'h0, tw[k]}, ras_pkg::RESP_OKAY);
    end
    wr(ras_pkg::OFS_INT_CLEAR, 32'h3);
    wr(ras_pkg::OFS_INT_ENABLE, 32'h1);
    for (k = 0; k < 4; k++) wr(6'(k * 4), {16'h0, tw[k]});
    // mask codes 0 to 10; code 10, past the year, never fires
    for (c = 0; c < 11; c++) begin
      wr(ras_pkg::OFS_CONTROL, 32'h1 | (32'(c) << 8));
      i_half_tick <= 1'b1;
      @(posedge i_clock);
      i_half_tick <= 1'b0;
      @(posedge i_clock);
      chk({31'h0, o_alarm_pulse}, {31'h0, c < 10});
      repeat (2) @(posedge i_clock);
      chk({31'h0, o_irq}, {31'h0, c < 10});
      rc(ras_pkg::OFS_STATUS, {31'h0, c < 10}, ras_pkg::RESP_OKAY);
      rc(ras_pkg::OFS_CONTROL, (32'(c) << 8) | {31'h0, c >= 10}, ras_pkg::RESP_OKAY);
      wr(ras_pkg::OFS_INT_CLEAR, 32'h1);
      repeat (2) @(posedge i_clock);
      chk({31'h0, o_irq}, 32'h0);
    end
    // a tick in the second half of the second leaves the every-second code armed
    wr(ras_pkg::OFS_CONTROL, 32'h1 | (32'(ras_pkg::AM_SECOND) << 8));
    i_second_half <= 1'b1;
    i_half_tick <= 1'b1;
    @(posedge i_clock);
    i_second_half <= 1'b0;
    i_half_tick <= 1'b0;
    @(posedge i_clock);
    chk({31'h0, o_alarm_pulse}, 32'h0);
    rc(ras_pkg::OFS_CONTROL, 32'h101, ras_pkg::RESP_OKAY);
    // unmapped read and a write to the read-only status
    rc(6'h3c, 32'h0, ras_pkg::RESP_SLVERR);
    wr(ras_pkg::OFS_STATUS, 32'h3);
    chk({30'h0, rsp}, {30'h0, ras_pkg::RESP_SLVERR});
    print_verdict();
  end
endmodule
